// ### core/lsrd_core.sv
// logical-shift-right decoder and executor behind a wishbone slave
// assumes a classic wishbone master on clk_i; one clock, sync reset
//
// Function
// (RULE_01) immediate forms shift source right with zero fill into destination
// (RULE_02) register forms take count from bottom eight bits of amount register
// (RULE_03) five-bit amount field zero means shift by 32
// (RULE_04) 32-bit compact form amount is upper:lower fields, zero means 32
// (RULE_05) flagged immediate form updates flags unless destination is program counter
// (RULE_06) flagged form to program counter branches and restores state from saved word
// (RULE_07) that return checks saved word for illegal return first
// (RULE_08) flagged form to program counter is undefined in hypervisor mode
// (RULE_09) in user and system mode the outcome is implementation choice
// (RULE_10) unflagged fixed form to program counter does interworking branch
// (RULE_11) fixed flagged form: cond not 1111, S one, bits 6:4 010
// (RULE_12) 16-bit immediate: top 000 01, amount, source, destination fields
// (RULE_13) 32-bit compact form needs shift type 01 in bits 5:4
// (RULE_14) 16-bit forms set flags only outside a conditional block
// (RULE_15) each encoding executes exactly as the matching register move
// (RULE_16) shift by 32 gives zero; carry is source bit 31; N,Z follow result
// (RULE_17) register count zero keeps value and carry; above 32 gives zero, carry 0
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module lsrd_core (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   output logic             irq_o
);
   // number of sticky event bits: done, no match, undefined, return, illegal return and branch
   localparam int NUM_EV_W = lsrd_pkg::NUM_EV;

   // one-cycle execute sequencer
   // the go bit is seen in idle, the instruction runs in the single exec
   // cycle, and every result register updates at the edge that leaves it;
   // a go written while exec is busy is kept, since the bus write wins over the self-clear, and runs again from idle
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } lsrd_state_e;

   lsrd_state_e state_q, state_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] insn_q, insn_d;
   logic [31:0] src_q, src_d;
   logic [31:0] amt_q, amt_d;
   logic [31:0] res_q, res_d;
   logic [31:0] saved_q, saved_d;
   logic [31:0] processor_state_word_q, processor_state_word_d;
   logic [NUM_EV_W-1:0] irq_q, irq_d;
   logic [NUM_EV_W-1:0] mask_q, mask_d;
   logic [3:0]  flags_q, flags_d;
   logic [3:0]  dest_q, dest_d;
   logic [2:0]  kind_q, kind_d;
   logic        ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic        err_q, err_d;

   // decode results
   logic        hit;
   logic        flagged;
   logic        by_reg;
   logic [5:0]  imm_cnt;
   logic [7:0]  cnt;
   logic [3:0]  rd;
   logic [31:0] shifted;
   logic        carry;
   logic        keep_c;
   logic [NUM_EV_W-1:0] ev;
   logic        wr, rd_en, mapped;
   logic [4:0]  mode;
   logic [31:0] ins;

   assign ins  = insn_q;
   assign mode = ctrl_q[lsrd_pkg::CTRL_MODE_LSB +: 5];

   // decode notes:
   //  - the three families are told apart by control bits, not by the word,
   //    so a 16-bit word is always taken from the low half of insn
   //  - every hit names its destination, even when nothing gets written
   //  - register forms leave imm_cnt at zero; the fix-up below turns that
   //    into 32, which is harmless because cnt then takes the amount register
   //  - a word that matches no form leaves hit low and is reported, not run
   //  - the 16-bit register form takes its count from amt like the other register forms,
   //    the destination doubling as source is a matter for the pipeline

   // instruction decode for all right-shift forms, aliases of move [RULE_15]
   always_comb begin
      hit     = 1'b0;
      flagged = 1'b0;
      by_reg  = 1'b0;
      imm_cnt = 6'h00;
      cnt     = 8'h00;
      rd      = 4'h0;
      if (!ctrl_q[lsrd_pkg::CTRL_THUMB_BIT]) begin
         // fixed-width immediate form [RULE_11]
         if (ins[31:28] != lsrd_pkg::COND_NEVER && ins[27:21] == 7'h0D
             && ins[19:16] == 4'h0 && ins[6:5] == lsrd_pkg::STYPE_LSR
             && !ins[4]) begin
            hit     = 1'b1;
            flagged = ins[20];
            rd      = ins[15:12];
            imm_cnt = {1'b0, ins[11:7]};
         end else if (ins[31:28] != lsrd_pkg::COND_NEVER && ins[27:21] == 7'h0D
                      && ins[19:16] == 4'h0 && ins[7:4] == {1'b0, lsrd_pkg::REGSHIFT_LSR}) begin
            hit     = 1'b1;
            by_reg  = 1'b1;
            flagged = ins[20];
            rd      = ins[15:12];
         end
      end else if (!ctrl_q[lsrd_pkg::CTRL_WIDE_BIT]) begin
         // 16-bit immediate form in low half [RULE_12] [RULE_14]
         if (ins[15:11] == 5'h01) begin
            hit     = 1'b1;
            flagged = !ctrl_q[lsrd_pkg::CTRL_IT_BIT];
            rd      = {1'b0, ins[2:0]};
            imm_cnt = {1'b0, ins[10:6]};
         end else if (ins[15:6] == 10'h103) begin
            // 16-bit register form, destination doubles as source [RULE_14]
            hit     = 1'b1;
            by_reg  = 1'b1;
            flagged = !ctrl_q[lsrd_pkg::CTRL_IT_BIT];
            rd      = {1'b0, ins[2:0]};
         end
      end else begin
         // 32-bit compact immediate form [RULE_13]
         if (ins[31:21] == 11'h752 && ins[19:16] == 4'hF && !ins[15]
             && ins[5:4] == lsrd_pkg::STYPE_LSR) begin
            hit     = 1'b1;
            flagged = ins[20];
            rd      = ins[11:8];
            imm_cnt = {1'b0, ins[14:12], ins[7:6]}; // [RULE_04]
         end else if (ins[31:21] == 11'h7D1 && ins[15:12] == 4'hF
                      && ins[7:4] == 4'h0) begin
            hit     = 1'b1;
            by_reg  = 1'b1;
            flagged = ins[20];
            rd      = ins[11:8];
         end
      end
      // zero amount field means 32 [RULE_03] [RULE_04]
      if (imm_cnt == 6'h00) begin
         imm_cnt = lsrd_pkg::SHIFT_FULL;
      end
      // only the bottom byte of the amount register counts [RULE_02]
      cnt = by_reg ? amt_q[7:0] : {2'b00, imm_cnt};
   end

   // zero-fill shifter with carry out [RULE_01] [RULE_16] [RULE_17]
   // counts 1 to 31 take the last bit shifted out as carry; exactly 32
   // empties the word and carries bit 31; anything larger empties the word
   // and clears carry; zero passes the word through and asks the flag
   // update to keep the old carry, so keep_c must win over carry there
   always_comb begin
      keep_c  = 1'b0;
      shifted = 32'h0000_0000;
      carry   = 1'b0;
      if (cnt == 8'h00) begin
         shifted = src_q;
         keep_c  = 1'b1; // [RULE_17]
      end else if (cnt < 8'h20) begin
         shifted = src_q >> cnt[4:0];
         carry   = src_q[cnt[4:0] - 5'd1];
      end else if (cnt == 8'h20) begin
         carry   = src_q[31]; // [RULE_16]
      end
   end

   // a request is new only while no answer stands for it; without the
   // err term a refused access would be answered twice, since the master
   // still holds cyc and stb in the cycle in which err shows
   assign wr     = cyc_i && stb_i && we_i && !ack_q && !err_q;
   assign rd_en  = cyc_i && stb_i && !we_i && !ack_q && !err_q;
   assign mapped = (adr_i <= lsrd_pkg::STATE_OFF) && (adr_i[1:0] == 2'b00);

   // next-state: register writes, execution, events
   // outcome kinds in status: 0 no match, 1 normal, 2 undefined,
   // 3 illegal return, 4 exception return
   // the exception-return path belongs to the fixed-width flagged immediate form only;
   // every other form that targets the program counter is a plain branch
   // a bus write in the same cycle as exec wins for the written register,
   // except the event bits, where a new event beats a clear
   always_comb begin
      state_d  = state_q;
      ctrl_d   = ctrl_q;
      insn_d   = insn_q;
      src_d    = src_q;
      amt_d    = amt_q;
      res_d    = res_q;
      saved_d  = saved_q;
      processor_state_word_d = processor_state_word_q;
      mask_d   = mask_q;
      flags_d  = flags_q;
      dest_d   = dest_q;
      kind_d   = kind_q;
      ev       = '0;
      ack_d    = 1'b0;
      err_d    = 1'b0;
      rdata_d  = 32'h0000_0000;
      ctrl_d[lsrd_pkg::CTRL_GO_BIT] = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (ctrl_q[lsrd_pkg::CTRL_GO_BIT]) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_d = ST_IDLE;
            ev[lsrd_pkg::EV_DONE] = 1'b1;
            dest_d = rd;
            if (!hit) begin
               ev[lsrd_pkg::EV_NONE] = 1'b1;
               kind_d = 3'h0;
            end else if (flagged && rd == lsrd_pkg::PC_REG && !by_reg
                         && !ctrl_q[lsrd_pkg::CTRL_THUMB_BIT]) begin
               if (mode == lsrd_pkg::MODE_HYP) begin
                  ev[lsrd_pkg::EV_UNDEF] = 1'b1; // [RULE_08]
                  kind_d = 3'h2;
               end else if (saved_q[lsrd_pkg::SAVED_IL_BIT]) begin
                  // illegal return: branch, keep state, flag it [RULE_07]
                  res_d = shifted;
                  ev[lsrd_pkg::EV_ILLEGAL] = 1'b1;
                  kind_d = 3'h3;
               end else begin
                  // user/system take the same return path [RULE_09]
                  res_d    = shifted;
                  processor_state_word_d = saved_q; // [RULE_06]
                  flags_d  = saved_q[31:28];
                  ev[lsrd_pkg::EV_ERET] = 1'b1;
                  kind_d = 3'h4;
               end
            end else begin
               res_d  = shifted; // [RULE_01] [RULE_02]
               kind_d = 3'h1;
               if (rd == lsrd_pkg::PC_REG) begin
                  ev[lsrd_pkg::EV_BRANCH] = 1'b1; // [RULE_10] low bit picks set
                  processor_state_word_d[5] = shifted[0];
               end else if (flagged) begin
                  // N Z C update, V kept [RULE_05] [RULE_16]
                  flags_d[3] = shifted[31];
                  flags_d[2] = (shifted == 32'h0000_0000);
                  flags_d[1] = keep_c ? flags_q[1] : carry;
                  processor_state_word_d[31:28] = {shifted[31], shifted == 32'h0000_0000,
                                     keep_c ? flags_q[1] : carry, flags_q[0]};
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // wishbone access
      if (wr && mapped) begin
         ack_d = 1'b1;
         case (adr_i)
            lsrd_pkg::CTRL_OFF:  ctrl_d  = dat_i;
            lsrd_pkg::INSN_OFF:  insn_d  = dat_i;
            lsrd_pkg::SRC_OFF:   src_d   = dat_i;
            lsrd_pkg::AMT_OFF:   amt_d   = dat_i;
            lsrd_pkg::MASK_OFF:  mask_d  = dat_i[NUM_EV_W-1:0];
            lsrd_pkg::SAVED_OFF: saved_d = dat_i;
            default: ;
         endcase
      end else if (rd_en && mapped) begin
         ack_d = 1'b1;
         case (adr_i)
            lsrd_pkg::CTRL_OFF:  rdata_d = ctrl_q;
            lsrd_pkg::INSN_OFF:  rdata_d = insn_q;
            lsrd_pkg::SRC_OFF:   rdata_d = src_q;
            lsrd_pkg::AMT_OFF:   rdata_d = amt_q;
            lsrd_pkg::RES_OFF:   rdata_d = res_q;
            lsrd_pkg::STAT_OFF:  rdata_d = {20'h00000, flags_q, dest_q, 1'b0, kind_q};
            lsrd_pkg::IRQ_OFF:   rdata_d = {26'h0, irq_q};
            lsrd_pkg::MASK_OFF:  rdata_d = {26'h0, mask_q};
            lsrd_pkg::SAVED_OFF: rdata_d = saved_q;
            lsrd_pkg::STATE_OFF: rdata_d = processor_state_word_q;
            default:             rdata_d = 32'h0000_0000;
         endcase
      end else if ((wr || rd_en) && !mapped) begin
         err_d = 1'b1;
      end
      // sticky events, set wins over write-one-to-clear
      irq_d = irq_q;
      if (wr && adr_i == lsrd_pkg::IRQ_OFF) begin
         irq_d = irq_q & ~dat_i[NUM_EV_W-1:0];
      end
      irq_d = irq_d | ev;
   end

   // register stage
   // every register but the state clears under reset, the state going to idle, so the bus answers and the interrupt
   // line are quiet from the first edge on and no stale event survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q  <= ST_IDLE;
         ctrl_q   <= lsrd_pkg::CTRL_RST;
         insn_q   <= 32'h0000_0000;
         src_q    <= 32'h0000_0000;
         amt_q    <= 32'h0000_0000;
         res_q    <= 32'h0000_0000;
         saved_q  <= 32'h0000_0000;
         processor_state_word_q <= 32'h0000_0000;
         irq_q    <= '0;
         mask_q   <= '0;
         flags_q  <= 4'h0;
         dest_q   <= 4'h0;
         kind_q   <= 3'h0;
         ack_q    <= 1'b0;
         err_q    <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         state_q  <= state_d;
         ctrl_q   <= ctrl_d;
         insn_q   <= insn_d;
         src_q    <= src_d;
         amt_q    <= amt_d;
         res_q    <= res_d;
         saved_q  <= saved_d;
         processor_state_word_q <= processor_state_word_d;
         irq_q    <= irq_d;
         mask_q   <= mask_d;
         flags_q  <= flags_d;
         dest_q   <= dest_d;
         kind_q   <= kind_d;
         ack_q    <= ack_d;
         err_q    <= err_d;
         rdata_q  <= rdata_d;
      end
   end

   // bus and interrupt outputs
   // read data and answers come straight from flip-flops; the interrupt
   // is an and-or of two registers, so it cannot glitch on bus traffic
   assign dat_o = rdata_q;
   assign ack_o = ack_q;
   assign err_o = err_q;
   assign irq_o = |(irq_q & mask_q);
endmodule : lsrd_core
`default_nettype wire

// ### core/lsrd_pkg.sv
// package for the right-shift decoder: encodings, fields, registers
// assumes nothing beyond a systemverilog compiler
package lsrd_pkg;
   // wishbone register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] INSN_OFF   = 8'h04;
   localparam logic [7:0] SRC_OFF    = 8'h08;
   localparam logic [7:0] AMT_OFF    = 8'h0C;
   localparam logic [7:0] RES_OFF    = 8'h10;
   localparam logic [7:0] STAT_OFF   = 8'h14;
   localparam logic [7:0] IRQ_OFF    = 8'h18;
   localparam logic [7:0] MASK_OFF   = 8'h1C;
   localparam logic [7:0] SAVED_OFF  = 8'h20;
   localparam logic [7:0] STATE_OFF  = 8'h24;
   // control register fields
   localparam int CTRL_GO_BIT    = 0;
   localparam int CTRL_THUMB_BIT = 1;
   localparam int CTRL_WIDE_BIT  = 2;
   localparam int CTRL_IT_BIT    = 3;
   localparam int CTRL_MODE_LSB  = 8;
   // processor modes
   localparam logic [4:0] MODE_USER = 5'h10;
   localparam logic [4:0] MODE_HYP  = 5'h1A;
   localparam logic [4:0] MODE_SYS  = 5'h1F;
   // saved state word: illegal-return bit
   localparam int SAVED_IL_BIT = 20;
   // event bits
   localparam int EV_DONE    = 0;
   localparam int EV_UNDEF   = 1;
   localparam int EV_ERET    = 2;
   localparam int EV_ILLEGAL = 3;
   localparam int EV_BRANCH  = 4;
   localparam int EV_NONE    = 5;
   localparam int NUM_EV     = 6;
   // fixed encodings
   localparam logic [3:0] COND_NEVER   = 4'hF;
   localparam logic [3:0] PC_REG       = 4'hF;
   localparam logic [1:0] STYPE_LSR    = 2'h1;
   localparam logic [2:0] REGSHIFT_LSR = 3'h3;
   localparam logic [5:0] SHIFT_FULL   = 6'h20;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
endpackage : lsrd_pkg

// ### test/lsrd_host.sv
// bus master model standing in for the pipeline that feeds the decoder
// assumes a classic wishbone slave that answers with ack or err
`timescale 1ns/1ns
`default_nettype none
module lsrd_host (
   input  wire logic        clk_i,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i,
   input  wire logic        err_i,
   output var  logic        cyc_o,
   output var  logic        stb_o,
   output var  logic        we_o,
   output var  logic [7:0]  adr_o,
   output var  logic [3:0]  sel_o,
   output var  logic [31:0] dat_o
);
   // idle bus at time zero, full words only
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hF;
      dat_o = 32'h0;
   end

   // one classic cycle; held until the answer, released at its edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      dat_o <= d;
      do @(posedge clk_i); while (!(ack_i || err_i));
      q = dat_i;
      e = err_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d;
      @(posedge clk_i);
   endtask : acc
endmodule : lsrd_host
`default_nettype wire

// ### test/lsrd_chk.sv
// checker: bus answer timing and interrupt line of the shift decoder
// assumes only the top ports; bound in below the module
`timescale 1ns/1ns
`default_nettype none
module lsrd_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // new request and whether its address is mapped
   logic req;
   logic ok_adr;
   assign req    = cyc_i && stb_i && !ack_o && !err_o;
   assign ok_adr = adr_i <= 8'h24 && adr_i[1:0] == 2'h0;

   ack_late_a : assert property (req && ok_adr |=> ack_o && !err_o) else $error("ack late");
   err_late_a : assert property (req && !ok_adr |=> err_o && !ack_o) else $error("err late");
   ack_pulse_a : assert property (ack_o |=> !ack_o) else $error("ack too long");
   err_pulse_a : assert property (err_o |=> !err_o) else $error("err too long");
   idle_quiet_a : assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
      else $error("answer without request");
   reset_vals_a : assert property ($fell(rst_i) |-> dat_o == 32'h0 && !ack_o && !irq_o)
      else $error("not cleared by reset");
   irq_cause_a : assert property ($rose(irq_o) |-> ack_o || $past(ack_o) || $past(ack_o, 2)
      || $past(ack_o, 3)) else $error("irq rose uncaused");
   irq_clear_a : assert property ($fell(irq_o) |-> ack_o || $past(ack_o))
      else $error("irq fell uncaused");

   cover property (err_o);
   cover property ($rose(irq_o));
   cover property ($fell(irq_o));
endmodule : lsrd_chk

bind lsrd_core lsrd_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .err_o(err_o), .irq_o(irq_o));
`default_nettype wire

// ### test/tb.sv
// self-checking bench: shift forms, return paths and interrupt
// assumes the decoder register map and one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, err, irq, e;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q, res_v;
   logic [32:0] x;
   int          n_fail = 0;
   int          checks = 0;
   int          ia[4] = '{0, 1, 4, 31};
   logic [31:0] ra[4] = '{32'h100, 32'h103, 32'h120, 32'h124};
   logic [4:0]  md[3] = '{5'h13, 5'h10, 5'h1F};

   always #10 clk_i = ~clk_i;

   lsrd_host host_u (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .err_i(err), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   lsrd_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
      .irq_o(irq));

   // reference shift: carry in bit 32, counts above 32 clear all
   function automatic logic [32:0] ref_lsr(input logic [31:0] s, input int n);
      logic [63:0] w;
      w = {s, 32'h0} >> n;
      return (n > 32) ? 33'h0 : {w[31], w[63:32]};
   endfunction : ref_lsr

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.acc(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      host_u.acc(1'b0, a, 32'h0, q, e);
   endtask : rd

   // load operands, fire one instruction, leave status in q
   task automatic ex(input logic [31:0] ctl, ins, src, amt);
      wr(lsrd_pkg::INSN_OFF, ins);
      wr(lsrd_pkg::SRC_OFF, src);
      wr(lsrd_pkg::AMT_OFF, amt);
      wr(lsrd_pkg::CTRL_OFF, ctl | 32'h1);
      rd(lsrd_pkg::RES_OFF);
      res_v = q;
      rd(lsrd_pkg::STAT_OFF);
   endtask : ex

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(lsrd_pkg::CTRL_OFF);
      `CHK("ctrl reset", 32'h0, q)
      rd(8'h28);
      `CHK("unmapped err", 1'b1, e)
      foreach (ia[i]) begin
         x = ref_lsr(32'h8000_00F0, (ia[i] == 0) ? 32 : ia[i]);
         ex(32'h0, 32'hE1B0_1022 | (32'(ia[i]) << 7), 32'h8000_00F0, 32'h0);
         `CHK("imm result", x[31:0], res_v)
         `CHK("imm status", {20'h0, x[31], x[31:0] == 0, x[32], 9'h011}, q)
      end
      ex(32'h0, 32'hF1B0_1022, 32'h1, 32'h0);
      `CHK("cond never", 3'h0, q[2:0])
      foreach (ra[i]) begin
         x = ref_lsr(32'hF000_000F, int'(ra[i][7:0]));
         ex(32'h0, 32'hE1A0_1231, 32'hF000_000F, ra[i]);
         `CHK("reg result", x[31:0], res_v)
      end
      $display("test fixed forms done");
      ex(32'h2, 32'h0813, 32'h8000_0001, 32'h0);
      `CHK("t16 result", 32'h0, res_v)
      `CHK("t16 status", 32'h0000_0631, q)
      ex(32'hA, 32'h0853, 32'h2, 32'h0);
      `CHK("cond blk result", 32'h1, res_v)
      `CHK("cond blk status", 32'h0000_0631, q)
      ex(32'h2, 32'h40D3, 32'h8000_00F0, 32'h104);
      `CHK("t16 reg result", 32'h0800_000F, res_v)
      `CHK("t16 reg status", 32'h0000_0031, q)
      ex(32'h6, 32'hEA5F_1251, 32'h8000_00F0, 32'h0);
      `CHK("t32 result", 32'h0400_0007, res_v)
      `CHK("t32 status", 32'h0000_0221, q)
      $display("test short forms done");
      ex(32'h1A00, 32'hE1B0_F0A2, 32'h4, 32'h0);
      `CHK("hyp undefined", 3'h2, q[2:0])
      `CHK("irq masked", 1'b0, irq)
      wr(lsrd_pkg::MASK_OFF, 32'h2);
      `CHK("irq raised", 1'b1, irq)
      wr(lsrd_pkg::IRQ_OFF, 32'h2);
      `CHK("irq cleared", 1'b0, irq)
      $display("test interrupt done");
      foreach (md[i]) begin
         wr(lsrd_pkg::SAVED_OFF, 32'h5000_0013);
         ex(32'(md[i]) << 8, 32'hE1B0_F0A2, 32'h4, 32'h0);
         `CHK("return kind", 3'h4, q[2:0])
         rd(lsrd_pkg::STATE_OFF);
         `CHK("state restored", 32'h5000_0013, q)
      end
      wr(lsrd_pkg::SAVED_OFF, 32'h0010_0010);
      ex(32'h1300, 32'hE1B0_F0A2, 32'h4, 32'h0);
      `CHK("illegal kind", 3'h3, q[2:0])
      rd(lsrd_pkg::STATE_OFF);
      `CHK("state kept", 32'h5000_0013, q)
      ex(32'h0, 32'hE1A0_F0A2, 32'h3, 32'h0);
      rd(lsrd_pkg::IRQ_OFF);
      `CHK("branch event", 1'b1, q[4])
      rd(lsrd_pkg::STATE_OFF);
      `CHK("branch set", 1'b1, q[5])
      $display("test return paths done");
      close_out();
   end
endmodule : tb
`default_nettype wire
